/* File: hw/mmd_attr_ctrl.sv */
// Access ordering, fetch protection and barrier control
`timescale 1ns/1ps
module mmd_attr_ctrl
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic [mmd_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_write,
    output logic req_ready,
    output logic bus_valid,
    output logic [mmd_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_write,
    output mmd_pkg::mmd_region_type bus_region,
    output mmd_pkg::mmd_mtype_type bus_mtype,
    output logic bus_execute_never,
    output logic bus_buf,
    input wire logic bus_ready,
    input wire logic bus_done,
    input wire mmd_pkg::mmd_mtype_type bus_done_mtype,
    input wire logic bus_done_buf,
    output logic ack_posted,
    output logic ack_done,
    input wire logic fetch_valid,
    input wire logic [mmd_pkg::ADDR_W-1:0] fetch_addr,
    output logic fetch_ready,
    output logic ifetch_valid,
    output logic [mmd_pkg::ADDR_W-1:0] ifetch_addr,
    input wire logic ifetch_ready,
    output logic mm_fault,
    output logic [mmd_pkg::ADDR_W-1:0] fault_addr,
    input wire logic bar_valid,
    input wire mmd_pkg::mmd_bar_kind_type bar_kind,
    output logic bar_ready,
    output logic bar_done,
    output logic exec_stall,
    output logic pipe_flush
);
    import mmd_pkg::*;

    mmd_region_type d_region;
    mmd_mtype_type d_mtype;
    logic d_noexec;
    mmd_region_type f_region;
    mmd_mtype_type f_mtype;
    logic f_noexec;

    // Pending data request, decoded on the cycle it is taken
    logic p_valid_reg;
    logic [ADDR_W-1:0] p_addr_reg;
    logic p_write_reg;
    mmd_region_type p_region_reg;
    mmd_mtype_type p_mtype_reg;
    logic p_noexec_reg;

    // Issued request presented on the system bus
    logic b_valid_reg;
    logic [ADDR_W-1:0] b_addr_reg;
    logic b_write_reg;
    mmd_region_type b_region_reg;
    mmd_mtype_type b_mtype_reg;
    logic b_noexec_reg;
    logic b_buf_reg;

    // Outstanding counts: all, Device plus Strongly-ordered, Strongly-ordered
    logic [OUT_W-1:0] cnt_all_reg;
    logic [OUT_W-1:0] cnt_ord_reg;
    logic [OUT_W-1:0] cnt_so_reg;

    logic f_valid_reg;
    logic [ADDR_W-1:0] f_addr_reg;
    logic fetch_ready_reg;
    logic req_ready_reg;
    logic mm_fault_reg;
    logic [ADDR_W-1:0] fault_addr_reg;
    logic ack_posted_reg;
    logic ack_done_reg;

    mmd_bar_state_type bar_state_reg;
    mmd_bar_state_type bar_state_next;
    mmd_bar_kind_type bar_kind_reg;
    logic bar_ready_reg;
    logic bar_done_reg;
    logic exec_stall_reg;
    logic pipe_flush_reg;

    mmd_region_decode u_data_decode
    (
        .addr(req_addr),
        .region(d_region),
        .mtype(d_mtype),
        .execute_never(d_noexec)
    );

    mmd_region_decode u_fetch_decode
    (
        .addr(fetch_addr),
        .region(f_region),
        .mtype(f_mtype),
        .execute_never(f_noexec)
    );

    wire take = req_valid & req_ready_reg; // RULE_24
    wire issue = b_valid_reg & bus_ready;
    wire slot_free = ~b_valid_reg | bus_ready;

    // Normal only waits for Strongly-ordered; it may pass earlier Device work
    wire gate_normal = (cnt_so_reg == OUT_ZERO); // RULE_02
    wire gate_device = (cnt_ord_reg == OUT_ZERO); // RULE_03 RULE_07
    wire gate_strong = (cnt_all_reg == OUT_ZERO); // RULE_04 RULE_23
    wire gate_type = (p_mtype_reg == MT_STRONG) ? gate_strong :
                     (p_mtype_reg == MT_DEVICE) ? gate_device :
                     gate_normal;
    wire gate_room = (cnt_all_reg != OUT_MAX);
    wire move = p_valid_reg & slot_free & gate_type & gate_room;

    wire p_valid_next = (p_valid_reg & ~move) | take;
    wire b_valid_next = (b_valid_reg & ~bus_ready) | move;
    // Strongly-ordered writes must complete before they are acknowledged
    wire buf_next = p_write_reg & (p_mtype_reg == MT_DEVICE); // RULE_05

    wire inc_all = move;
    wire inc_ord = move & (p_mtype_reg != MT_NORMAL);
    wire inc_so = move & (p_mtype_reg == MT_STRONG);
    wire dec_all = bus_done;
    wire dec_ord = bus_done & (bus_done_mtype != MT_NORMAL);
    wire dec_so = bus_done & (bus_done_mtype == MT_STRONG);

    wire [OUT_W-1:0] cnt_all_next = cnt_all_reg + {{(OUT_W-1){1'b0}}, inc_all} - {{(OUT_W-1){1'b0}}, dec_all};
    wire [OUT_W-1:0] cnt_ord_next = cnt_ord_reg + {{(OUT_W-1){1'b0}}, inc_ord} - {{(OUT_W-1){1'b0}}, dec_ord};
    wire [OUT_W-1:0] cnt_so_next = cnt_so_reg + {{(OUT_W-1){1'b0}}, inc_so} - {{(OUT_W-1){1'b0}}, dec_so};

    // Earlier requests already taken must reach the bus and complete
    wire drained = ~p_valid_reg & ~b_valid_reg & (cnt_all_reg == OUT_ZERO); // RULE_15 RULE_16
    wire bar_take = bar_valid & bar_ready_reg;

    always_comb
    begin
        bar_state_next = bar_state_reg;
        unique case (bar_state_reg)
            BS_IDLE:
            begin
                if (bar_take)
                    bar_state_next = BS_DRAIN;
            end
            BS_DRAIN:
            begin
                if (drained)
                    bar_state_next = (bar_kind_reg == BK_INSTR) ? BS_FLUSH : BS_DONE; // RULE_17
            end
            BS_FLUSH:
                bar_state_next = BS_DONE;
            BS_DONE:
                bar_state_next = BS_IDLE;
        endcase
    end

    // New data requests are refused while any barrier is in progress
    wire req_ready_next = ~p_valid_next & (bar_state_next == BS_IDLE); // RULE_15
    wire sync_stall_next = (bar_state_next == BS_DRAIN) & ((bar_state_reg == BS_IDLE) ? (bar_kind == BK_SYNC) :
                           (bar_kind_reg == BK_SYNC)); // RULE_16

    wire f_take = fetch_valid & fetch_ready_reg;
    wire f_load = f_take & ~f_noexec; // RULE_06
    wire f_valid_next = (f_valid_reg & ~ifetch_ready) | f_load;
    // Fetch is held off during the flush so refetch sees completed writes
    wire fetch_ready_next = ~f_valid_next & (bar_state_next != BS_FLUSH); // RULE_17

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            p_valid_reg <= 1'b0;
            b_valid_reg <= 1'b0;
            req_ready_reg <= 1'b0;
            cnt_all_reg <= OUT_ZERO;
            cnt_ord_reg <= OUT_ZERO;
            cnt_so_reg <= OUT_ZERO;
            ack_posted_reg <= 1'b0;
            ack_done_reg <= 1'b0;
        end
        else
        begin
            p_valid_reg <= p_valid_next;
            b_valid_reg <= b_valid_next;
            req_ready_reg <= req_ready_next;
            cnt_all_reg <= cnt_all_next;
            cnt_ord_reg <= cnt_ord_next;
            cnt_so_reg <= cnt_so_next;
            ack_posted_reg <= issue & b_buf_reg; // RULE_05
            ack_done_reg <= bus_done & ~bus_done_buf;
        end
    end

    // Datapath registers need no reset; valids qualify them
    always_ff @(posedge sys_clk)
    begin
        if (take)
        begin
            p_addr_reg <= req_addr;
            p_write_reg <= req_write;
            p_region_reg <= d_region;
            p_mtype_reg <= d_mtype;
            p_noexec_reg <= d_noexec;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (move)
        begin
            b_addr_reg <= p_addr_reg;
            b_write_reg <= p_write_reg;
            b_region_reg <= p_region_reg;
            b_mtype_reg <= p_mtype_reg;
            b_noexec_reg <= p_noexec_reg;
            b_buf_reg <= buf_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            f_valid_reg <= 1'b0;
            fetch_ready_reg <= 1'b0;
            mm_fault_reg <= 1'b0;
            fault_addr_reg <= '0;
        end
        else
        begin
            f_valid_reg <= f_valid_next;
            fetch_ready_reg <= fetch_ready_next;
            mm_fault_reg <= f_take & f_noexec; // RULE_06
            if (f_take & f_noexec)
                fault_addr_reg <= fetch_addr;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (f_load)
            f_addr_reg <= fetch_addr;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bar_state_reg <= BS_IDLE;
            bar_kind_reg <= BK_DATA;
            bar_ready_reg <= 1'b0;
            bar_done_reg <= 1'b0;
            exec_stall_reg <= 1'b0;
            pipe_flush_reg <= 1'b0;
        end
        else
        begin
            bar_state_reg <= bar_state_next;
            if (bar_take)
                bar_kind_reg <= bar_kind;
            bar_ready_reg <= (bar_state_next == BS_IDLE);
            bar_done_reg <= (bar_state_next == BS_DONE);
            exec_stall_reg <= sync_stall_next; // RULE_16
            pipe_flush_reg <= (bar_state_next == BS_FLUSH); // RULE_17
        end
    end

    assign req_ready = req_ready_reg;
    assign bus_valid = b_valid_reg;
    assign bus_addr = b_addr_reg;
    assign bus_write = b_write_reg;
    assign bus_region = b_region_reg;
    assign bus_mtype = b_mtype_reg;
    assign bus_execute_never = b_noexec_reg;
    assign bus_buf = b_buf_reg;
    assign ack_posted = ack_posted_reg;
    assign ack_done = ack_done_reg;
    assign fetch_ready = fetch_ready_reg;
    assign ifetch_valid = f_valid_reg;
    assign ifetch_addr = f_addr_reg;
    assign mm_fault = mm_fault_reg;
    assign fault_addr = fault_addr_reg;
    assign bar_ready = bar_ready_reg;
    assign bar_done = bar_done_reg;
    assign exec_stall = exec_stall_reg;
    assign pipe_flush = pipe_flush_reg;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence flush_tail_s;
        pipe_flush ##1 (bar_done && !pipe_flush);
    endsequence

    sequence plain_tail_s;
        !pipe_flush && bar_done;
    endsequence

    strong_alone_a: assert property ( // RULE_04
        move && p_mtype_reg == MT_STRONG |=> cnt_all_reg == OUT_ONE && cnt_so_reg == OUT_ONE)
        else $error("strongly-ordered access issued with others outstanding");

    device_order_a: assert property ( // RULE_07
        move && p_mtype_reg == MT_DEVICE |=> cnt_ord_reg == OUT_ONE)
        else $error("device access issued past an earlier ordered access");

    strong_nobuf_a: assert property ( // RULE_05
        bus_valid && bus_mtype == MT_STRONG |-> !bus_buf)
        else $error("strongly-ordered write marked bufferable");

    noexec_block_a: assert property ( // RULE_06
        f_take && f_noexec |=> mm_fault && fault_addr == $past(fetch_addr) && !(ifetch_valid && !$past(f_valid_reg)))
        else $error("execute-never fetch not blocked and faulted");

    priv_type_a: assert property ( // RULE_13
        take && req_addr >= PRIV_BASE && req_addr < SYSDEV_BASE |=> p_mtype_reg == MT_STRONG && p_noexec_reg)
        else $error("private peripheral bus access mistyped");

    periph_type_a: assert property ( // RULE_10
        take && req_addr >= PERIPH_BASE && req_addr < EXTRAM_BASE |=> p_mtype_reg == MT_DEVICE && p_noexec_reg)
        else $error("peripheral access mistyped");

    code_exec_a: assert property ( // RULE_11
        f_take && fetch_addr < EXTDEV_BASE && (fetch_addr < PERIPH_BASE || fetch_addr >= EXTRAM_BASE)
        |=> !mm_fault && ifetch_valid)
        else $error("fetch from executable region refused");

    barrier_hold_a: assert property ( // RULE_15
        bar_take |=> !req_ready [*2])
        else $error("data request accepted while a barrier drains");

    sync_stall_a: assert property ( // RULE_16
        bar_take && bar_kind == BK_SYNC |=> exec_stall throughout (bar_state_reg == BS_DRAIN) [*1])
        else $error("execution not stalled by sync barrier");

    sync_release_a: assert property ( // RULE_16
        exec_stall && drained |=> !exec_stall ##0 plain_tail_s)
        else $error("sync barrier not released once drained");

    // Flush pulse is registered, so it follows the drained cycle
    instr_flush_a: assert property ( // RULE_17
        bar_state_reg == BS_DRAIN && drained && bar_kind_reg == BK_INSTR |=> flush_tail_s)
        else $error("instruction barrier flush sequence wrong");

    data_finish_a: assert property ( // RULE_15
        bar_state_reg == BS_DRAIN && drained && bar_kind_reg == BK_DATA |-> ##[0:1] plain_tail_s)
        else $error("data barrier did not finish after drain");

endmodule : mmd_attr_ctrl

/* File: hw/mmd_pkg.sv */
// Constants and types for the memory map attribute decoder
// Summary of operation
// [RULE_01] Fixed 4 GB map, one region per address
// [RULE_02] Normal accesses may reorder or speculate
// [RULE_03] Device keeps order with Device/Strongly-ordered
// [RULE_04] Strongly-ordered keeps order with everything
// [RULE_05] Device writes bufferable, Strongly-ordered writes never
// [RULE_06] Fetch from execute-never region faults, blocked
// [RULE_07] Earlier Device/SO observed before later Device
// [RULE_08] Code region: Normal, executable
// [RULE_09] SRAM region: Normal, executable
// [RULE_10] Peripheral region: Device, execute-never
// [RULE_11] External RAM: Normal, executable
// [RULE_12] External device, system peripherals: Device, execute-never
// [RULE_13] Private peripheral bus: Strongly-ordered, execute-never
// [RULE_14] Software should place code in code region
// [RULE_15] Data barrier holds later transactions until drained
// [RULE_16] Sync barrier stalls execution until drained
// [RULE_17] Instruction barrier flushes after completed transactions
// [RULE_18] Software uses data barrier after vector change
// [RULE_19] Software uses instruction barrier after self-modification
// [RULE_20] Software uses sync barrier after map switch
// [RULE_21] Software uses sync barrier after priority change
// [RULE_22] Multi-master semaphores need data barrier after
// [RULE_23] Strongly-ordered accesses ordered without any barrier
// [RULE_24] Decode is one combinational stage, same cycle
package mmd_pkg;

    localparam int ADDR_W = 32;
    localparam int OUT_W = 4;

    localparam logic [ADDR_W-1:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [ADDR_W-1:0] PERIPH_BASE = 32'h4000_0000;
    localparam logic [ADDR_W-1:0] EXTRAM_BASE = 32'h6000_0000;
    localparam logic [ADDR_W-1:0] EXTDEV_BASE = 32'hA000_0000;
    localparam logic [ADDR_W-1:0] PRIV_BASE = 32'hE000_0000;
    localparam logic [ADDR_W-1:0] SYSDEV_BASE = 32'hE010_0000;

    localparam logic [OUT_W-1:0] OUT_ZERO = 4'h0;
    localparam logic [OUT_W-1:0] OUT_ONE = 4'h1;
    localparam logic [OUT_W-1:0] OUT_MAX = 4'hF;

    typedef enum logic [2:0] {
        REG_CODE = 3'h0,
        REG_SRAM = 3'h1,
        REG_PERIPH = 3'h2,
        REG_EXTRAM = 3'h3,
        REG_EXTDEV = 3'h4,
        REG_PRIV = 3'h5,
        REG_SYSDEV = 3'h6
    } mmd_region_type;

    typedef enum logic [1:0] {
        MT_NORMAL = 2'h0,
        MT_DEVICE = 2'h1,
        MT_STRONG = 2'h2
    } mmd_mtype_type;

    typedef enum logic [1:0] {
        BK_DATA = 2'h0,
        BK_SYNC = 2'h1,
        BK_INSTR = 2'h2
    } mmd_bar_kind_type;

    typedef enum logic [1:0] {
        BS_IDLE = 2'h0,
        BS_DRAIN = 2'h1,
        BS_FLUSH = 2'h2,
        BS_DONE = 2'h3
    } mmd_bar_state_type;

endpackage : mmd_pkg

/* File: hw/mmd_region_decode.sv */
// Combinational address to region, memory type and execute-never decode
`timescale 1ns/1ps
module mmd_region_decode
(
    input wire logic [mmd_pkg::ADDR_W-1:0] addr,
    output mmd_pkg::mmd_region_type region,
    output mmd_pkg::mmd_mtype_type mtype,
    output logic execute_never
);
    import mmd_pkg::*;

    // Ordered compares; every 32-bit address lands in exactly one region
    wire in_sram = addr >= SRAM_BASE;
    wire in_periph = addr >= PERIPH_BASE;
    wire in_extram = addr >= EXTRAM_BASE;
    wire in_extdev = addr >= EXTDEV_BASE;
    wire in_priv = addr >= PRIV_BASE;
    wire in_sysdev = addr >= SYSDEV_BASE;

    assign region = in_sysdev ? REG_SYSDEV : // RULE_12
                    in_priv ? REG_PRIV : // RULE_13
                    in_extdev ? REG_EXTDEV : // RULE_12
                    in_extram ? REG_EXTRAM : // RULE_11
                    in_periph ? REG_PERIPH : // RULE_10
                    in_sram ? REG_SRAM : // RULE_09
                    REG_CODE; // RULE_08

    // RULE_01
    assign mtype = (region == REG_PRIV) ? MT_STRONG :
                   (region == REG_PERIPH || region == REG_EXTDEV || region == REG_SYSDEV) ? MT_DEVICE :
                   MT_NORMAL;

    // Only the Normal regions can hold code
    assign execute_never = (mtype != MT_NORMAL); // RULE_11

endmodule : mmd_region_decode

/* File: bench/mmd_bus_model.sv */
// Behavioural memories and peripherals on the far side of the attribute decoder
`timescale 1ns/1ps
module mmd_bus_model
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic bus_valid,
    input wire mmd_pkg::mmd_mtype_type bus_mtype,
    input wire logic bus_buf,
    output logic bus_ready,
    output logic bus_done,
    output mmd_pkg::mmd_mtype_type bus_done_mtype,
    output logic bus_done_buf,
    input wire logic ifetch_valid,
    output logic ifetch_ready,
    input wire logic [31:0] accept_wait,
    input wire logic [31:0] done_wait
);
    import mmd_pkg::*;

    logic [2:0] q [$];
    logic [2:0] h;
    int wcnt;
    int dcnt;

    initial
    begin
        bus_ready = 1'b0;
        bus_done = 1'b0;
        bus_done_mtype = MT_NORMAL;
        bus_done_buf = 1'b0;
        ifetch_ready = 1'b0;
    end

    always @(posedge sys_clk)
    begin
        bus_ready <= 1'b0;
        bus_done <= 1'b0;
        // Qualifiers toggle while idle so a stale value never passes for a real one
        bus_done_buf <= ~bus_done_buf;
        bus_done_mtype <= mmd_mtype_type'(~bus_done_mtype);
        ifetch_ready <= ifetch_valid && !ifetch_ready;
        if (srst)
        begin
            wcnt <= 0;
            dcnt <= 0;
            q.delete();
        end
        else
        begin
            if (bus_valid && !bus_ready)
            begin
                wcnt <= (wcnt >= accept_wait) ? 0 : wcnt + 1;
                if (wcnt >= accept_wait)
                begin
                    bus_ready <= 1'b1;
                    q.push_back({bus_buf, bus_mtype});
                end
            end
            if (q.size() > 0)
            begin
                dcnt <= (dcnt >= done_wait) ? 0 : dcnt + 1;
                if (dcnt >= done_wait)
                begin
                    h = q.pop_front();
                    bus_done <= 1'b1;
                    bus_done_buf <= h[2];
                    bus_done_mtype <= mmd_mtype_type'(h[1:0]);
                end
            end
        end
    end
endmodule : mmd_bus_model

/* File: bench/test_memory_map_attribute_decoder.sv */
// Self-checking bench for the memory map attribute decoder
`timescale 1ns/1ps
module test_memory_map_attribute_decoder;
    import mmd_pkg::*;

    logic sys_clk, srst, req_valid, req_write, req_ready, bus_valid, bus_write, bus_execute_never;
    logic bus_buf, bus_ready, bus_done, bus_done_buf, ack_posted, ack_done, fetch_valid, fetch_ready;
    logic ifetch_valid, ifetch_ready, mm_fault, bar_valid, bar_ready, bar_done, exec_stall, pipe_flush;
    logic [ADDR_W-1:0] req_addr, bus_addr, fetch_addr, ifetch_addr, fault_addr;
    mmd_region_type bus_region;
    mmd_mtype_type bus_mtype, bus_done_mtype;
    mmd_bar_kind_type bar_kind;
    int fail_count = 0, checks = 0, aw = 0, dw = 2;
    int n_iss = 0, n_done = 0, n_post = 0, n_flush = 0, out_at = 0, iss_mark = 0;
    // Region boundaries, both ends of every region
    logic [31:0] ta [14] = '{32'h0000_0000, 32'h1FFF_FFFF, 32'h2000_0000, 32'h3FFF_FFFF, 32'h4000_0000,
        32'h5FFF_FFFF, 32'h6000_0000, 32'h9FFF_FFFF, 32'hA000_0000, 32'hDFFF_FFFF, 32'hE000_0000,
        32'hE00F_FFFF, 32'hE010_0000, 32'hFFFF_FFFF};
    int tr [14] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6};
    int tm [14] = '{0, 0, 0, 0, 1, 1, 0, 0, 1, 1, 2, 2, 1, 1};
    int nox [14] = '{0, 0, 0, 0, 1, 1, 0, 0, 1, 1, 1, 1, 1, 1};
    logic [31:0] oa [5] = '{32'h4000_0000, 32'h4000_0004, 32'h2000_0000, 32'hE000_E010, 32'hA000_0000};
    int oe [5] = '{0, 0, 1, 0, 0};
    wire [9:0] s = {mm_fault | ifetch_valid, bar_ready, fetch_ready, req_ready, n_iss != iss_mark,
        n_iss == n_done, bar_done, ack_posted, ack_done, bus_valid};

    mmd_attr_ctrl i_dut (.sys_clk, .srst, .req_valid, .req_addr, .req_write, .req_ready, .bus_valid,
        .bus_addr, .bus_write, .bus_region, .bus_mtype, .bus_execute_never, .bus_buf, .bus_ready,
        .bus_done, .bus_done_mtype, .bus_done_buf, .ack_posted, .ack_done, .fetch_valid, .fetch_addr,
        .fetch_ready, .ifetch_valid, .ifetch_addr, .ifetch_ready, .mm_fault, .fault_addr, .bar_valid,
        .bar_kind, .bar_ready, .bar_done, .exec_stall, .pipe_flush);

    mmd_bus_model i_bus (.sys_clk, .srst, .bus_valid, .bus_mtype, .bus_buf, .bus_ready, .bus_done,
        .bus_done_mtype, .bus_done_buf, .ifetch_valid, .ifetch_ready, .accept_wait(aw), .done_wait(dw));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Issue and completion bookkeeping, independent of the design's counters
    always @(posedge sys_clk)
    begin
        if (bus_valid && bus_ready)
        begin
            out_at <= n_iss - n_done;
            n_iss <= n_iss + 1;
        end
        n_done <= n_done + bus_done;
        n_post <= n_post + ack_posted;
        n_flush <= n_flush + pipe_flush;
    end

    task end_sim;
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task timed_out;
        fail_count++;
        $display("ERROR %0t wait ran out", $time);
        end_sim();
    endtask : timed_out

    task chk(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task wait_for(int k, int n);
        int i;
        for (i = 0; i < n && s[k] !== 1'b1; i++)
            @(posedge sys_clk) #1;
        if (s[k] !== 1'b1)
            timed_out();
    endtask : wait_for

    // Holds whichever request is raised until its ready is seen at an edge
    task hs(int r);
        int i;
        for (i = 0; i < 60; i++)
        begin
            @(posedge sys_clk);
            if (s[r] === 1'b1)
                break;
        end
        #1;
        req_valid = 1'b0;
        fetch_valid = 1'b0;
        bar_valid = 1'b0;
        if (i == 60)
            timed_out();
    endtask : hs

    task req(logic [31:0] a, logic w);
        req_addr = a;
        req_write = w;
        req_valid = 1'b1;
        hs(6);
    endtask : req

    task s_decode;
        for (int i = 0; i < 14; i++)
        begin
            iss_mark = n_iss;
            req(ta[i], 1'b0);
            wait_for(0, 20);
            chk(bus_addr, ta[i]);
            chk(bus_write, 1'b0);
            chk(bus_region, tr[i]);
            chk(bus_mtype, tm[i]);
            chk(bus_execute_never, nox[i]);
            // Let this access leave the bus so the next look sees the new one
            wait_for(5, 20);
        end
        wait_for(4, 60);
    endtask : s_decode

    task s_fetch;
        for (int i = 0; i < 14; i++)
        begin
            fetch_addr = ta[i];
            fetch_valid = 1'b1;
            hs(7);
            wait_for(9, 4);
            chk(mm_fault, nox[i]);
            chk(ifetch_valid, !nox[i]);
            chk(nox[i] ? fault_addr : ifetch_addr, ta[i]);
            @(posedge sys_clk) #1;
        end
    endtask : s_fetch

    // Slow completions expose whether each issue waited for the ones before it
    task s_order;
        aw = 2;
        for (int i = 0; i < 5; i++)
        begin
            iss_mark = n_iss;
            req(oa[i], 1'b0);
            wait_for(5, 80);
            chk(out_at, oe[i]);
        end
        wait_for(4, 80);
        aw = 0;
    endtask : s_order

    task s_wbuf;
        int d;
        d = n_done;
        req(32'h4000_0010, 1'b1);
        wait_for(0, 20);
        chk(bus_buf, 1'b1);
        chk(bus_write, 1'b1);
        wait_for(2, 20);
        chk(n_done, d);
        wait_for(4, 80);
        d = n_post;
        req(32'hE000_ED00, 1'b1);
        wait_for(0, 20);
        chk(bus_buf, 1'b0);
        wait_for(1, 80);
        chk(n_iss - n_done, 0);
        chk(n_post, d);
    endtask : s_wbuf

    task s_barrier;
        int f;
        for (int k = 0; k < 3; k++)
        begin
            req(32'h4000_0020, 1'b0);
            wait_for(0, 20);
            f = n_flush;
            // Software side: one barrier of each kind, each after a Device read
            bar_kind = mmd_bar_kind_type'(k);
            bar_valid = 1'b1;
            hs(8);
            @(posedge sys_clk) #1;
            chk(exec_stall, k == 1);
            chk(req_ready, 1'b0);
            wait_for(3, 80);
            chk(n_iss - n_done, 0);
            chk(n_flush - f, k == 2);
        end
    endtask : s_barrier

    initial
    begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_addr = '0;
        req_write = 1'b0;
        fetch_valid = 1'b0;
        fetch_addr = '0;
        bar_valid = 1'b0;
        bar_kind = BK_DATA;
        repeat (12) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        @(posedge sys_clk) #1;
        s_decode();
        s_fetch();
        dw = 15;
        s_order();
        s_wbuf();
        s_barrier();
        end_sim();
    end
endmodule : test_memory_map_attribute_decoder
